/* File: bench/sbacr_top_asserts.sv */
/* sbacr_top_asserts: port-level checks of the slot B configuration registers.
   Bound into sbacr_top; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module sbacr_top_asserts (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // register port
   input wire sbacr_pkg::sbacr_req_s req_i,
   input wire logic [15:0] rdata_o,
   input wire logic rvalid_o,
   // neighbouring controls
   input wire logic [5:0] b_ext_gain_i,
   input wire logic integrate_gap_enable_i,
   input wire logic b_single_pair_select_i,
   // decoded configuration
   input wire sbacr_pkg::sbacr_cfg_s cfg_o,
   input wire logic path_reserved_o
);
   // copies the two-flop release so checks start when the design listens
   logic [1:0] live_q;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) live_q <= 2'h0;
      else live_q <= {live_q[0], 1'b1};
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!live_q[1]);
   a_timing_store: assert property (req_i.wr && req_i.addr == 8'h3b
      |=> {cfg_o.b_window_width, cfg_o.b_window_coarse_delay, cfg_o.b_window_fine_delay}
      == $past(req_i.wdata)) else $error("timing fields wrong");
   a_mode_store: assert property (req_i.wr && req_i.addr == 8'h44
      |=> cfg_o.b_path_mode_select == $past(req_i.wdata[15:8])) else $error("mode wrong");
   a_gain_split: assert property (req_i.wr && req_i.addr == 8'h44 && req_i.wdata[6]
      |=> cfg_o.b_channel_gain == {$past(b_ext_gain_i), $past(req_i.wdata[1:0])})
      else $error("split gain wrong");
   a_gain_shared: assert property (req_i.wr && req_i.addr == 8'h44 && !req_i.wdata[6]
      |=> cfg_o.b_channel_gain == {4{$past(req_i.wdata[1:0])}}) else $error("shared gain wrong");
   a_conn_flag: assert property (req_i.wr && req_i.addr == 8'h45
      |=> path_reserved_o == !($past(req_i.wdata) inside {16'hada5, 16'hb065, 16'hae65}))
      else $error("reserved flag wrong");
   a_enable_store: assert property (req_i.wr && req_i.addr == 8'h58
      |=> {cfg_o.b_digital_integrate_enable, cfg_o.a_digital_integrate_enable}
      == $past(req_i.wdata[13:12])) else $error("enables wrong");
   a_gap_follow: assert property (!req_i.wr
      |=> cfg_o.b_gap_delay == ($past(integrate_gap_enable_i) ? cfg_o.b_window_fine_delay : 5'h0))
      else $error("gap wrong");
   a_pair_follow: assert property (b_single_pair_select_i
      |=> cfg_o.b_single_pair_select) else $error("pair select wrong");
   a_read_pulse: assert property (req_i.rd |=> rvalid_o ##0 !$stable(rvalid_o) || $past(rvalid_o))
      else $error("read pulse wrong");
endmodule : sbacr_top_asserts
bind sbacr_top sbacr_top_asserts i_sbacr_top_asserts (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
   .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .b_ext_gain_i(b_ext_gain_i),
   .integrate_gap_enable_i(integrate_gap_enable_i), .cfg_o(cfg_o),
   .b_single_pair_select_i(b_single_pair_select_i), .path_reserved_o(path_reserved_o));
`default_nettype wire

/* File: bench/tb.sv */
/* tb: self-checking bench for sbacr_top; access table, then decode and reset cases.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   sbacr_pkg::sbacr_req_s req = '0;
   logic [15:0] rdata;
   logic rvalid;
   logic pres;
   logic [5:0] ext = 6'h0;
   logic gap = 1'b0;
   logic sp = 1'b0;
   sbacr_pkg::sbacr_cfg_s cfg;
   int num_errors = 0;
   int checked = 0;
   // index, write data, read back
   localparam logic [39:0] ROWS [7] = '{{8'h3b, 16'hffff, 16'hffff}, {8'h3b, 16'h0, 16'h0},
      {8'h44, 16'h1d41, 16'h1d41}, {8'h45, 16'hae65, 16'hae65}, {8'h58, 16'h3000, 16'h3000},
      {8'h58, 16'h0, 16'h0}, {8'h10, 16'hffff, 16'h0}};
   sbacr_top i_sbacr_top (.clk_sys_i(clk), .rstn_i(rstn), .req_i(req), .rdata_o(rdata),
      .rvalid_o(rvalid), .b_ext_gain_i(ext), .integrate_gap_enable_i(gap),
      .b_single_pair_select_i(sp), .cfg_o(cfg), .path_reserved_o(pres));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      req <= {w, r, a, d};
      @(negedge clk);
      req <= '0;
   endtask : acc
   task automatic rd(input logic [7:0] a, input logic [15:0] x);
      acc(1'b0, 1'b1, a, 16'h0);
      `CHK(rvalid, 1'b1)
      `CHK(rdata, x)
   endtask : rd
   task automatic wrap_up;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   // the sequence needs about 80 cycles
   initial begin
      #100000;
      num_errors++;
      wrap_up();
   end
   initial begin
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      foreach (ROWS[i]) begin
         acc(1'b1, 1'b0, ROWS[i][39:32], ROWS[i][31:16]);
         rd(ROWS[i][39:32], ROWS[i][15:0]);
      end
      ext <= 6'h39;
      acc(1'b1, 1'b0, 8'h44, 16'h1c41);
      `CHK(cfg.b_channel_gain, 8'he5)
      for (int k = 0; k < 4; k++) begin
         acc(1'b1, 1'b0, 8'h44, {8'h1c, 6'h0, k[1:0]});
         `CHK(cfg.b_channel_gain, {4{k[1:0]}})
      end
      acc(1'b1, 1'b0, 8'h45, 16'h1234);
      `CHK(pres, 1'b1)
      acc(1'b1, 1'b0, 8'h45, 16'hb065);
      `CHK(pres, 1'b0)
      gap <= 1'b1;
      sp <= 1'b1;
      acc(1'b1, 1'b0, 8'h3b, 16'h0013);
      `CHK(cfg.b_gap_delay, 5'h13)
      `CHK(cfg.b_single_pair_select, 1'b1)
      // same-cycle read and write: the read sees the old contents
      acc(1'b1, 1'b1, 8'h58, 16'h2000);
      `CHK(rdata, 16'h0)
      `CHK({cfg.b_digital_integrate_enable, cfg.a_digital_integrate_enable}, 2'h2)
      rstn <= 1'b0;
      @(negedge clk);
      rstn <= 1'b1;
      repeat (3) @(negedge clk);
      rd(8'h3b, 16'h22fc);
      rd(8'h44, 16'h1c38);
      rd(8'h58, 16'h0);
      `CHK(cfg.b_window_width, 5'h04)
      `CHK(cfg.b_window_coarse_delay, 6'h17)
      `CHK(cfg.b_window_fine_delay, 5'h1c)
      `CHK(cfg.b_path_mode_select, 8'h1c)
      `CHK(cfg.b_path_connection, 16'hada5)
      `CHK(cfg.b_channel_gain, 8'h00)
      `CHK(pres, 1'b0)
      wrap_up();
   end
endmodule : tb
`default_nettype wire

/* File: verilog/sbacr_pkg.sv */
/*
 * sbacr_pkg: register offsets, field positions, reset values and carrier
 * types for the slot B front-end configuration register group.
 * Assumes an 8-bit register index and 16-bit register data, as seen by the
 * device's internal register port behind its serial control interface.
 */
package sbacr_pkg;

   // register indices
   localparam logic [7:0] OFS_WINDOW_TIMING = 8'h3b;
   localparam logic [7:0] OFS_MODE_GAIN = 8'h44;
   localparam logic [7:0] OFS_PATH_CONN = 8'h45;
   localparam logic [7:0] OFS_INT_ENABLE = 8'h58;

   // reset values of whole registers, reserved bits included
   localparam logic [15:0] RST_WINDOW_TIMING = 16'h22fc;
   localparam logic [15:0] RST_MODE_GAIN = 16'h1c38;
   localparam logic [15:0] RST_PATH_CONN = 16'hada5;
   localparam logic [15:0] RST_INT_ENABLE = 16'h0000;

   // window timing fields
   localparam int WIDTH_LSB = 11;
   localparam int WIDTH_W = 5;
   localparam int COARSE_LSB = 5;
   localparam int COARSE_W = 6;
   localparam int FINE_LSB = 0;
   localparam int FINE_W = 5;
   // fine step, in picoseconds
   localparam int FINE_STEP_PS = 31250;

   // mode and gain fields
   localparam int MODE_LSB = 8;
   localparam int MODE_W = 8;
   localparam int PER_CH_GAIN_BIT = 6;
   localparam int GAIN_LSB = 0;
   localparam int GAIN_W = 2;

   // path mode codes
   localparam logic [7:0] MODE_NORMAL = 8'h1c;
   localparam logic [7:0] MODE_DIG_INT = 8'h1d;

   // path connection codes
   localparam logic [15:0] CONN_FULL_ANALOG_PATH = 16'hada5;
   localparam logic [15:0] CONN_AMP_TO_CONVERTER_PATH = 16'hb065;
   localparam logic [15:0] CONN_DIG_INT_PATH = 16'hae65;

   // integration enable fields
   localparam int B_DIG_INT_BIT = 13;
   localparam int A_DIG_INT_BIT = 12;

   // gain codes: 200k, 100k, 50k, 25k ohm
   typedef enum logic [1:0] {
      GAIN_200K = 2'h0,
      GAIN_100K = 2'h1,
      GAIN_50K = 2'h2,
      GAIN_25K = 2'h3
   } sbacr_gain_e;

   // register write/read request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } sbacr_req_s;

   // decoded configuration handed to the slot B front end
   typedef struct packed {
      logic [4:0] b_window_width;
      logic [5:0] b_window_coarse_delay;
      logic [4:0] b_window_fine_delay;
      logic [4:0] b_gap_delay;
      logic [7:0] b_path_mode_select;
      logic [15:0] b_path_connection;
      logic [3:0][1:0] b_channel_gain;
      logic b_single_pair_select;
      logic b_digital_integrate_enable;
      logic a_digital_integrate_enable;
   } sbacr_cfg_s;

   typedef enum logic {
      PATH_VALID,
      PATH_RESERVED
   } sbacr_path_e;

endpackage : sbacr_pkg

/* File: verilog/sbacr_top.sv */
/*
 * sbacr_top: slot B front-end configuration registers (window timing,
 * path mode, gain codes, path connection, digital integration enables)
 * and their decoding into per-channel settings.
 * Assumes a register port on clk_sys_i already decoded from the serial
 * control interface, and per-channel gains and gap/sample-pair controls
 * held by neighbouring register groups on the same clock.
 */
// Function
// - timing bits 15..11 hold window width in microseconds, reset 4.
// - timing bits 10..5 hold coarse window delay in microseconds, reset 0x17.
// - timing bits 4..0 hold fine delay, 31.25 ns steps, reset 0x1c.
// - per-channel enable set: channel 1 own code, channels 2-4 from external.
// - per-channel enable clear: slot gain code drives all four channels.
// - two-bit gain code 0..3 means 200k, 100k, 50k, 25k ohm; reset 0.
// - integration enable bit 13 turns on slot B digital integration.
// - integration enable bit 12 turns on slot A digital integration.
// - with gap mode enabled the fine delay sets the sample-region gap.
// - sample-mode bit clear means double pair, set means single pair.
`timescale 1ns/1ps
`default_nettype none

module sbacr_top (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // register port
   input wire sbacr_pkg::sbacr_req_s req_i,
   output logic [15:0] rdata_o,
   output logic rvalid_o,
   // controls held by neighbouring registers
   input wire logic [5:0] b_ext_gain_i,
   input wire logic integrate_gap_enable_i,
   input wire logic b_single_pair_select_i,
   // decoded configuration
   output sbacr_pkg::sbacr_cfg_s cfg_o,
   output logic path_reserved_o
);

   typedef struct packed {
      logic [15:0] timing;
      logic [15:0] mode_gain;
      logic [15:0] path_conn;
      logic [15:0] int_en;
      logic [15:0] rdata;
      logic rvalid;
      sbacr_pkg::sbacr_cfg_s cfg;
      sbacr_pkg::sbacr_path_e path_state;
   } sbacr_state_s;

   sbacr_state_s state_q;
   sbacr_state_s state_d;
   logic [1:0] rst_sync_q;
   logic rstn_sync;

   // reset release is synchronised so every state_q flop leaves reset on one edge
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rstn_sync = rst_sync_q[1];

   function automatic logic [15:0] read_mux(input logic [7:0] addr, input sbacr_state_s s);
      case (addr)
         sbacr_pkg::OFS_WINDOW_TIMING: read_mux = s.timing;
         sbacr_pkg::OFS_MODE_GAIN: read_mux = s.mode_gain;
         sbacr_pkg::OFS_PATH_CONN: read_mux = s.path_conn;
         sbacr_pkg::OFS_INT_ENABLE: read_mux = s.int_en;
         default: read_mux = 16'h0000;
      endcase
   endfunction : read_mux

   function automatic logic path_is_known(input logic [15:0] conn);
      path_is_known = (conn == sbacr_pkg::CONN_FULL_ANALOG_PATH) ||
                      (conn == sbacr_pkg::CONN_AMP_TO_CONVERTER_PATH) ||
                      (conn == sbacr_pkg::CONN_DIG_INT_PATH);
   endfunction : path_is_known

   always_comb begin
      state_d = state_q;
      state_d.rvalid = req_i.rd;
      if (req_i.rd) begin
         state_d.rdata = read_mux(req_i.addr, state_q);
      end
      // every bit is read/write; reserved bits keep what software wrote
      if (req_i.wr) begin
         case (req_i.addr)
            sbacr_pkg::OFS_WINDOW_TIMING: state_d.timing = req_i.wdata;
            sbacr_pkg::OFS_MODE_GAIN: state_d.mode_gain = req_i.wdata;
            sbacr_pkg::OFS_PATH_CONN: state_d.path_conn = req_i.wdata;
            sbacr_pkg::OFS_INT_ENABLE: state_d.int_en = req_i.wdata;
            default: ;
         endcase
      end

      // outputs are decoded from the next register values so they follow a write by one edge
      state_d.cfg.b_window_width =
         state_d.timing[sbacr_pkg::WIDTH_LSB +: sbacr_pkg::WIDTH_W];
      state_d.cfg.b_window_coarse_delay =
         state_d.timing[sbacr_pkg::COARSE_LSB +: sbacr_pkg::COARSE_W];
      state_d.cfg.b_window_fine_delay =
         state_d.timing[sbacr_pkg::FINE_LSB +: sbacr_pkg::FINE_W];
      state_d.cfg.b_gap_delay = integrate_gap_enable_i ?
         state_d.timing[sbacr_pkg::FINE_LSB +: sbacr_pkg::FINE_W] : 5'h00;
      // mode codes are passed through untouched; only 0x1c and 0x1d are meaningful
      state_d.cfg.b_path_mode_select =
         state_d.mode_gain[sbacr_pkg::MODE_LSB +: sbacr_pkg::MODE_W];
      state_d.cfg.b_path_connection = state_d.path_conn;
      state_d.cfg.b_channel_gain[0] =
         state_d.mode_gain[sbacr_pkg::GAIN_LSB +: sbacr_pkg::GAIN_W];
      for (int ch = 1; ch < 4; ch++) begin
         if (state_d.mode_gain[sbacr_pkg::PER_CH_GAIN_BIT]) begin
            state_d.cfg.b_channel_gain[ch] = b_ext_gain_i[2*(ch-1) +: 2];
         end else begin
            state_d.cfg.b_channel_gain[ch] =
               state_d.mode_gain[sbacr_pkg::GAIN_LSB +: sbacr_pkg::GAIN_W];
         end
      end
      state_d.cfg.b_single_pair_select = b_single_pair_select_i;
      state_d.cfg.b_digital_integrate_enable =
         state_d.int_en[sbacr_pkg::B_DIG_INT_BIT];
      state_d.cfg.a_digital_integrate_enable =
         state_d.int_en[sbacr_pkg::A_DIG_INT_BIT];
      // reserved connection codes are flagged, not blocked: the analog side decides
      state_d.path_state = path_is_known(state_d.path_conn) ?
         sbacr_pkg::PATH_VALID : sbacr_pkg::PATH_RESERVED;
   end

   always_ff @(posedge clk_sys_i or negedge rstn_sync) begin
      if (!rstn_sync) begin
         state_q.timing <= sbacr_pkg::RST_WINDOW_TIMING;
         state_q.mode_gain <= sbacr_pkg::RST_MODE_GAIN;
         state_q.path_conn <= sbacr_pkg::RST_PATH_CONN;
         state_q.int_en <= sbacr_pkg::RST_INT_ENABLE;
         state_q.rdata <= 16'h0000;
         state_q.rvalid <= 1'b0;
         state_q.cfg.b_window_width <= 5'h04;
         state_q.cfg.b_window_coarse_delay <= 6'h17;
         state_q.cfg.b_window_fine_delay <= 5'h1c;
         state_q.cfg.b_gap_delay <= 5'h00;
         state_q.cfg.b_path_mode_select <= sbacr_pkg::MODE_NORMAL;
         state_q.cfg.b_path_connection <= sbacr_pkg::RST_PATH_CONN;
         state_q.cfg.b_channel_gain <= 8'h00;
         state_q.cfg.b_single_pair_select <= 1'b0;
         state_q.cfg.b_digital_integrate_enable <= 1'b0;
         state_q.cfg.a_digital_integrate_enable <= 1'b0;
         state_q.path_state <= sbacr_pkg::PATH_VALID;
      end else begin
         state_q <= state_d;
      end
   end

   assign rdata_o = state_q.rdata;
   assign rvalid_o = state_q.rvalid;
   assign cfg_o = state_q.cfg;
   assign path_reserved_o = (state_q.path_state == sbacr_pkg::PATH_RESERVED);

endmodule : sbacr_top

`default_nettype wire
